// *** hw/filter_pkg.sv ***
// Constants and carrier types for the per-channel offset filter.
// Assumes a single 25 MHz clock and a plain register port.
package filter_pkg;

    localparam int          AMP_CH      = 32;
    localparam int          CHAN_W      = 6;
    localparam int          DATA_W      = 16;
    localparam int          FRAC_W      = 15;
    localparam int          ST_W        = DATA_W + FRAC_W;
    localparam int          CUT_W       = 4;
    localparam int          ADDR_W      = 6;
    localparam int          REG_W       = 8;

    // Register index of the filter configuration and of the status word
    localparam logic [ADDR_W-1:0] REG_DSP_ADDR  = 6'h04;
    localparam logic [ADDR_W-1:0] REG_STAT_ADDR = 6'h10;

    // Field positions inside the configuration register
    localparam int          CUT_LSB     = 0;
    localparam int          EN_BIT      = 4;
    localparam int          RECT_BIT    = 5;

    localparam logic [CUT_W-1:0]  CUT_RST  = 4'h0;
    localparam logic              EN_RST   = 1'b0;
    localparam logic              RECT_RST = 1'b0;

    // Results travel in offset binary; flipping the top bit gives two's complement
    localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
    localparam logic [DATA_W-1:0] SMAX      = 16'h7fff;
    localparam logic [DATA_W-1:0] SMIN      = 16'h8000;
    localparam logic [CUT_W-1:0]  CUT_DIFF  = 4'h0;

    typedef struct packed {
        logic              valid;
        logic              clear;
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } conv_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } conv_res_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } reg_req_t;

endpackage

// *** hw/sat_sub.sv ***
// Signed subtract with clamping to the 16-bit range.
// Purely combinational; the caller registers the result.
module sat_sub
    import filter_pkg::*;
(
    input  wire logic signed [DATA_W-1:0] i_a,
    input  wire logic signed [DATA_W-1:0] i_b,
    output logic signed [DATA_W-1:0]      o_y
);
    logic signed [DATA_W:0] wide;

    always_comb
    begin
        wide = {i_a[DATA_W-1], i_a} - {i_b[DATA_W-1], i_b};
        // Two top bits disagreeing means the true value left the range
        if (wide[DATA_W] != wide[DATA_W-1])
            o_y = wide[DATA_W] ? SMIN : SMAX;
        else
            o_y = wide[DATA_W-1:0];
    end
endmodule

// *** hw/abs_rect.sv ***
// Absolute value of a signed 16-bit word.
// The most negative input has no positive twin and clamps to the maximum.
module abs_rect
    import filter_pkg::*;
(
    input  wire logic signed [DATA_W-1:0] i_x,
    output logic signed [DATA_W-1:0]      o_y
);
    always_comb
    begin
        if (i_x == SMIN)
            o_y = SMAX;
        else if (i_x[DATA_W-1])
            o_y = -i_x;
        else
            o_y = i_x;
    end
endmodule

// *** hw/offset_filter.sv ***
// Per-channel high-pass offset filter with optional rectification.
// Assumes one convert request per command frame, data already converted,
// and a register master that never issues write and read together.
//
// Contract
// - High-pass filtering acts only while the filter enable bit is set.
// - Only channels 0-31 are processed; other channels pass unchanged.
// - Every amplifier channel has its own single-pole IIR high-pass.
// - Cutoff index N from 1 to 15 sets pole at 1 - 2^-N.
// - Cutoff scales with each channel's own sample rate, not aggregate.
// - Index zero outputs current result minus the channel's previous result.
// - Filter output clamps at the signed 16-bit limits, never wraps.
// - A channel's state changes only when that channel is converted.
// - Convert with clear bit set zeroes the selected channel's state.
// - Rectify enable makes every amplifier result non-negative.
// - Each convert request yields one conversion of the addressed channel.
module offset_filter
    import filter_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rstn,
    input  wire filter_pkg::conv_req_t i_conv,
    input  wire filter_pkg::reg_req_t  i_bus,
    output filter_pkg::conv_res_t      o_result,
    output logic [filter_pkg::REG_W-1:0] o_reg_rdata
);
    import filter_pkg::*;

    localparam int IDX_W = $clog2(AMP_CH);

    typedef struct packed {
        logic [AMP_CH-1:0][ST_W-1:0] st;
        logic                        en;
        logic                        rect;
        logic [CUT_W-1:0]            cut;
        logic [CHAN_W-1:0]           last_ch;
        logic [REG_W-1:0]            rdata;
        logic                        res_valid;
        logic [DATA_W-1:0]           res;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic                     is_amp;
    logic [IDX_W-1:0]         idx;
    logic signed [DATA_W-1:0] x_s;
    logic signed [ST_W-1:0]   s_cur;
    logic signed [DATA_W-1:0] s_int;
    logic signed [DATA_W-1:0] y_hp;
    logic signed [DATA_W-1:0] y_filt;
    logic signed [DATA_W-1:0] y_abs;
    logic signed [DATA_W-1:0] y_out;
    logic signed [ST_W:0]     diff;
    logic signed [ST_W:0]     step;
    logic signed [ST_W-1:0]   s_new;

    // Channel numbers 32 and up are auxiliary, temperature or supply readings
    assign is_amp = (i_conv.chan < CHAN_W'(AMP_CH));
    assign idx    = i_conv.chan[IDX_W-1:0];
    assign x_s    = signed'(i_conv.data ^ SIGN_FLIP);

    // A clear takes effect on this very conversion
    assign s_cur  = i_conv.clear ? '0 : signed'(state_reg.st[idx]);
    assign s_int  = s_cur[ST_W-1:FRAC_W];

    sat_sub u_sat_sub
    (
        .i_a (x_s),
        .i_b (s_int),
        .o_y (y_hp)
    );

    // Raw result when disabled; rectify sits after this stage
    assign y_filt = state_reg.en ? y_hp : x_s;

    abs_rect u_abs_rect
    (
        .i_x (y_filt),
        .o_y (y_abs)
    );

    assign y_out = state_reg.rect ? y_abs : y_filt;

    // Tracker moves 2^-N of the way toward the input whenever, with the filter enabled, the channel
    // is converted, so the cutoff is tied to that channel's own rate.
    // With N of zero the tracker becomes the last sample: a differentiator.
    always_comb
    begin
        diff  = {x_s[DATA_W-1], x_s, FRAC_W'(0)} - {s_cur[ST_W-1], s_cur};
        step  = diff >>> state_reg.cut;
        s_new = s_cur + step[ST_W-1:0];
    end

    always_comb
    begin
        state_next           = state_reg;
        state_next.res_valid = 1'b0;
        state_next.rdata     = '0;

        if (i_bus.wr && (i_bus.addr == REG_DSP_ADDR))
        begin
            state_next.cut  = i_bus.wdata[CUT_LSB +: CUT_W];
            state_next.en   = i_bus.wdata[EN_BIT];
            state_next.rect = i_bus.wdata[RECT_BIT];
        end

        if (i_bus.rd)
        begin
            case (i_bus.addr)
                REG_DSP_ADDR:
                begin
                    state_next.rdata[CUT_LSB +: CUT_W] = state_reg.cut;
                    state_next.rdata[EN_BIT]           = state_reg.en;
                    state_next.rdata[RECT_BIT]         = state_reg.rect;
                end
                REG_STAT_ADDR:
                begin
                    state_next.rdata[CHAN_W-1:0] = state_reg.last_ch;
                end
                default:
                begin
                    state_next.rdata = '0;
                end
            endcase
        end

        if (i_conv.valid)
        begin
            state_next.res_valid = 1'b1;
            state_next.last_ch   = i_conv.chan;
            if (is_amp)
            begin
                state_next.res = y_out ^ SIGN_FLIP;
                // Only the addressed entry is written
                if (state_reg.en)
                    state_next.st[idx] = s_new;
                else if (i_conv.clear)
                    state_next.st[idx] = '0;
            end
            else
            begin
                state_next.res = i_conv.data;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            state_reg           <= '0;
            state_reg.cut       <= CUT_RST;
            state_reg.en        <= EN_RST;
            state_reg.rect      <= RECT_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_result.valid = state_reg.res_valid;
    assign o_result.data  = state_reg.res;
    assign o_reg_rdata    = state_reg.rdata;

    // Checks

    logic signed [DATA_W:0] chk_wide;
    assign chk_wide = {x_s[DATA_W-1], x_s} - {s_int[DATA_W-1], s_int};

    sequence s_cfg_write;
        i_bus.wr && (i_bus.addr == REG_DSP_ADDR);
    endsequence

    sequence s_cfg_read;
        i_bus.rd && (i_bus.addr == REG_DSP_ADDR) && !i_bus.wr;
    endsequence

    property p_cfg_readback;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_cfg_write ##1 s_cfg_read) |=>
            (o_reg_rdata[CUT_LSB +: CUT_W] == $past(i_bus.wdata[CUT_LSB +: CUT_W], 2)) &&
            (o_reg_rdata[EN_BIT] == $past(i_bus.wdata[EN_BIT], 2));
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("config readback mismatch");

    property p_aux_pass;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && !is_amp) |=> o_result.valid && (o_result.data == $past(i_conv.data));
    endproperty
    a_aux_pass: assert property (p_aux_pass)
        else $error("non amplifier channel was modified");

    property p_bypass;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && !state_reg.en && !state_reg.rect) |=>
            (o_result.data == $past(i_conv.data));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("disabled filter altered data");

    property p_one_result;
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_conv.valid |=> o_result.valid ##1 (o_result.valid == $past(i_conv.valid));
    endproperty
    a_one_result: assert property (p_one_result)
        else $error("result count does not follow requests");

    property p_no_spurious;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_conv.valid |=> !o_result.valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("result without request");

    property p_clear_raw;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && i_conv.clear && state_reg.en && !state_reg.rect) |=>
            (o_result.data == $past(i_conv.data));
    endproperty
    a_clear_raw: assert property (p_clear_raw)
        else $error("clear did not zero channel state");

    property p_diff_state;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.en && (state_reg.cut == CUT_DIFF)) |=>
            (state_reg.st[$past(idx)] == {$past(x_s), FRAC_W'(0)});
    endproperty
    a_diff_state: assert property (p_diff_state)
        else $error("differentiator did not keep last sample");

    property p_other_kept;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && (i_conv.chan != '0)) |=> $stable(state_reg.st[0]);
    endproperty
    a_other_kept: assert property (p_other_kept)
        else $error("channel 0 state changed by another channel");

    property p_idle_kept;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_conv.valid |=> (state_reg.st == $past(state_reg.st));
    endproperty
    a_idle_kept: assert property (p_idle_kept)
        else $error("filter state moved without conversion");

    property p_sat_high;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.en && !state_reg.rect &&
         !chk_wide[DATA_W] && chk_wide[DATA_W-1]) |=> (o_result.data == (SMAX ^ SIGN_FLIP));
    endproperty
    a_sat_high: assert property (p_sat_high)
        else $error("positive overflow wrapped");

    property p_sat_low;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.en && !state_reg.rect &&
         chk_wide[DATA_W] && !chk_wide[DATA_W-1]) |=> (o_result.data == (SMIN ^ SIGN_FLIP));
    endproperty
    a_sat_low: assert property (p_sat_low)
        else $error("negative overflow wrapped");

    property p_rectified;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.rect) |=> o_result.data[DATA_W-1];
    endproperty
    a_rectified: assert property (p_rectified)
        else $error("rectified result negative");

    property p_hp_step;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.en && !i_conv.clear && (state_reg.cut != CUT_DIFF)
         && (x_s == s_int) && (s_cur[FRAC_W-1:0] == '0)) |=> $stable(state_reg.st);
    endproperty
    a_hp_step: assert property (p_hp_step)
        else $error("settled tracker moved");

    // Aux readings must not disturb any amplifier's tracker
    property p_aux_state;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && !is_amp) |=> $stable(state_reg.st);
    endproperty
    a_aux_state: assert property (p_aux_state)
        else $error("aux reading moved filter state");

    property p_frozen;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && !state_reg.en && !i_conv.clear) |=> $stable(state_reg.st);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("disabled filter moved state");

    property p_clear_off;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && !state_reg.en && i_conv.clear) |=>
            (state_reg.st[$past(idx)] == '0);
    endproperty
    a_clear_off: assert property (p_clear_off)
        else $error("clear ignored while filter off");

    // With the filter on and rectify off, output is input minus tracker whenever the subtraction stays in range
    property p_hp_out;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.en && !state_reg.rect &&
         (chk_wide[DATA_W] == chk_wide[DATA_W-1])) |=>
            (o_result.data == ($past(chk_wide[DATA_W-1:0]) ^ SIGN_FLIP));
    endproperty
    a_hp_out: assert property (p_hp_out)
        else $error("filter output differs from input minus tracker");

    property p_rect_keep;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.rect && !y_filt[DATA_W-1]) |=>
            (o_result.data == ($past(y_filt) ^ SIGN_FLIP));
    endproperty
    a_rect_keep: assert property (p_rect_keep)
        else $error("rectifier altered a positive result");

    // The most negative value has no positive twin, so it clamps
    property p_rect_low;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_conv.valid && is_amp && state_reg.rect && (y_filt == SMIN)) |=>
            (o_result.data == (SMAX ^ SIGN_FLIP));
    endproperty
    a_rect_low: assert property (p_rect_low)
        else $error("rectified minimum did not clamp");

    // One kept-check per channel catches a stray write to any entry
    generate
        for (genvar g = 0; g < AMP_CH; g++)
        begin : g_kept
            property p_chan_kept;
                @(posedge i_core_clk) disable iff (!i_rstn)
                (i_conv.valid && !(is_amp && (idx == IDX_W'(g)))) |=> $stable(state_reg.st[g]);
            endproperty
            a_chan_kept: assert property (p_chan_kept)
                else $error("unaddressed channel state changed");
        end
    endgenerate

endmodule

// *** verif/conv_host.sv ***
// Host controller model that issues convert commands to the filter.
// Assumes the bench hands it at most one command per cycle on i_go.
module conv_host
    import filter_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_go,
    input  wire logic              i_clear,
    input  wire logic [CHAN_W-1:0] i_chan,
    input  wire logic [DATA_W-1:0] i_data,
    output filter_pkg::conv_req_t  o_conv
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_conv = '0;
    always @(posedge i_core_clk)
    begin
        if (i_go)
            o_conv <= '{valid: 1'b1, clear: i_clear, chan: i_chan, data: i_data};
        else
            // Idle fields toggle so a stale command never looks valid by luck
            o_conv <= '{valid: 1'b0, clear: ~o_conv.clear, chan: ~o_conv.chan, data: ~o_conv.data};
    end
endmodule

// *** verif/per_channel_offset_filter_tb_top.sv ***
// Bench for the offset filter: host model, reference model, queued checks.
// Assumes one-cycle answers on both the convert stream and the register port.
module per_channel_offset_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import filter_pkg::*;
    logic                   core_clk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   go = 1'b0;
    logic                   gclr = 1'b0;
    logic [CHAN_W-1:0]      gch = '0;
    logic [DATA_W-1:0]      gd = '0;
    reg_req_t               bus = '0;
    conv_req_t              conv;
    conv_res_t              res;
    logic [REG_W-1:0]       rdata;
    logic                   rd_seen = 1'b0;
    logic                   v_d = 1'b0;
    int                     error_cnt = 0;
    int                     comparisons = 0;
    int                     cycles = 0;
    logic [31:0]            rnd = 32'h51c7;
    logic [5:0]             cfg = '0;
    logic [CHAN_W-1:0]      last_ch = '0;
    logic signed [ST_W-1:0] st [AMP_CH];
    logic [DATA_W-1:0]      resq [$];
    logic [REG_W-1:0]       rdq [$];

    always #20 core_clk = ~core_clk;

    conv_host host_u (.i_core_clk(core_clk), .i_go(go), .i_clear(gclr), .i_chan(gch), .i_data(gd), .o_conv(conv));
    offset_filter dut_u (.i_core_clk(core_clk), .i_rstn(rstn), .i_conv(conv), .i_bus(bus),
                         .o_result(res), .o_reg_rdata(rdata));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic fail_msg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        error_cnt++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask

    task automatic chk_res(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) fail_msg(got, exp);
    endtask

    task automatic chk_reg(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        comparisons++;
        if (got !== exp) fail_msg({8'h00, got}, {8'h00, exp});
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) fail_msg({15'h0, got}, {15'h0, exp});
    endtask

    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic conv_cmd(input logic [CHAN_W-1:0] ch, input logic clr, input logic [DATA_W-1:0] d);
        logic signed [DATA_W-1:0] x;
        logic signed [DATA_W-1:0] y;
        logic signed [ST_W-1:0]   s;
        logic signed [31:0]       t;
        x = d ^ SIGN_FLIP;
        y = x;
        if (ch < AMP_CH)
        begin
            s = clr ? '0 : st[ch];
            if (cfg[EN_BIT])
            begin
                t = x - $signed(s[ST_W-1:FRAC_W]);
                y = (t > 32767) ? SMAX : (t < -32768) ? SMIN : t[DATA_W-1:0];
                t = $signed({x, 15'h0}) - s;
                st[ch] = ST_W'(s + (t >>> cfg[3:0]));
            end
            else if (clr)
                st[ch] = '0;
            if (cfg[RECT_BIT] && y < 0)
                y = (y == SMIN) ? SMAX : -y;
        end
        resq.push_back(y ^ SIGN_FLIP);
        last_ch = ch;
        @(posedge core_clk);
        go <= 1'b1;
        gch <= ch;
        gclr <= clr;
        gd <= d;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk) go <= 1'b0;
    endtask

    // Register tasks drop the convert strobe so a held go never repeats a command
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
        if (a == REG_DSP_ADDR) cfg = v[5:0];
        @(posedge core_clk);
        go <= 1'b0;
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge core_clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        rdq.push_back(a == REG_DSP_ADDR ? {2'b0, cfg} : a == REG_STAT_ADDR ? {2'b0, last_ch} : 8'h00);
        @(posedge core_clk);
        go <= 1'b0;
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
    endtask

    // Config write with its readback in the very next cycle, no gap
    task automatic wrrd(input logic [REG_W-1:0] v);
        cfg = v[5:0];
        rdq.push_back({2'b0, cfg});
        @(posedge core_clk);
        go <= 1'b0;
        bus <= '{wr: 1'b1, rd: 1'b0, addr: REG_DSP_ADDR, wdata: v};
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: REG_DSP_ADDR, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
    endtask

    // Random round robin over all amplifier channels at one steady rate
    task automatic sweep(input int rounds);
        for (int r = 0; r < rounds * AMP_CH; r++)
        begin
            rnd = lfsr(rnd);
            conv_cmd(6'(r % AMP_CH), rnd[31] & rnd[30] & rnd[29], rnd[15:0]);
        end
        idle(3);
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            error_cnt++;
            conclude();
        end
    end

    always @(posedge core_clk)
    begin
        if (rstn)
        begin
            chk_bit(res.valid, v_d);
            if (res.valid === 1'b1)
                chk_res(res.data, resq.size() ? resq.pop_front() : ~res.data);
            chk_reg(rdata, rd_seen ? (rdq.size() ? rdq.pop_front() : ~rdata) : 8'h00);
        end
        rd_seen <= bus.rd;
        v_d <= conv.valid;
    end

    initial
    begin
        // Mirrors the design's reset of every tracker
        foreach (st[i]) st[i] = '0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(REG_DSP_ADDR);
        wr(6'h3f, 8'hff);
        wr(REG_STAT_ADDR, 8'hff);
        rd(REG_DSP_ADDR);
        rd(6'h21);
        sweep(1);
        wr(REG_DSP_ADDR, 8'h14);
        for (int c = 32; c < 50; c += 4) conv_cmd(6'(c), 1'b0, 16'h0123);
        idle(3);
        rd(REG_STAT_ADDR);
        wr(REG_DSP_ADDR, 8'h10);
        conv_cmd(6'd3, 1'b1, 16'hffff);
        conv_cmd(6'd4, 1'b0, 16'h1234);
        conv_cmd(6'd3, 1'b0, 16'h0000);
        conv_cmd(6'd3, 1'b0, 16'hffff);
        idle(3);
        // Tracker already equals the input, so the first cutoff-4 step must not move it
        wrrd(8'h14);
        conv_cmd(6'd3, 1'b0, 16'hffff);
        idle(3);
        for (int n = 0; n < 16; n++)
        begin
            wr(REG_DSP_ADDR, 8'(8'h10 | n));
            sweep(3);
        end
        wr(REG_DSP_ADDR, 8'h00);
        conv_cmd(6'd7, 1'b0, 16'h4000);
        wr(REG_DSP_ADDR, 8'h10);
        conv_cmd(6'd7, 1'b0, 16'h9000);
        wr(REG_DSP_ADDR, 8'h34);
        conv_cmd(6'd5, 1'b1, 16'h0000);
        sweep(2);
        wr(REG_DSP_ADDR, 8'h20);
        sweep(1);
        conv_cmd(6'd40, 1'b0, 16'h0100);
        idle(3);
        rd(REG_STAT_ADDR);
        idle(4);
        conclude();
    end
endmodule
